// ===== hdl/bus_sampler.sv
// two-flop synchroniser and edge finder for scl and sda
// assumes the lines come straight from pins on another timebase
`default_nettype none
module bus_sampler (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire expander_pkg::bus_lines_t pins,
  output expander_pkg::bus_lines_t     lines,
  output expander_pkg::bus_events_t    events
);
  expander_pkg::bus_lines_t meta_reg;
  expander_pkg::bus_lines_t sync_reg;
  expander_pkg::bus_lines_t prev_reg;

  // idle bus reads high, so reset to high avoids a false start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end else begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // only the second flop and its delayed copy feed the edge logic
  assign lines        = sync_reg;
  assign events.rise  = sync_reg.scl & ~prev_reg.scl;
  assign events.fall  = ~sync_reg.scl & prev_reg.scl;
  assign events.start = sync_reg.scl & prev_reg.scl & prev_reg.sda & ~sync_reg.sda;
  assign events.stop  = sync_reg.scl & prev_reg.scl & ~prev_reg.sda & sync_reg.sda;
endmodule
`default_nettype wire

// ===== hdl/expander_pkg.sv
// constants and carrier types for the sixteen-bit i2c port expander
// assumes a single 125 MHz clock; bus pins arrive unsynchronised
// Operation
// R1: master writes high into every pin it uses as input
// R2: read returns pin level, which equals latch for driven outputs
// R3: alert line signals changed port data without bus traffic
// R4: master writes tied pins of one octal to equal values
// R5: each completed write byte is latched at ack clock, ack or nack
// R6: write bytes go low octal, high octal, alternating until stop
// R7: any write byte refreshes read snapshot and clears all alerts
// R8: read byte shift register loads current octal pins at byte start
// R9: read bytes return low octal first then high, alternating
// R10: reading low byte clears only low octal pending change
// R11: reading high byte clears only high octal pending change
// R12: in reset all sixteen latches preset to one, bus logic idle
// R13: address read/write bit zero selects write transfer
// R14: address read/write bit one selects read transfer
// R15: any port input edge sets pending change and pulls alert low
// R16: one pending flag per octal; alert low while either is set
`default_nettype none
package expander_pkg;
  localparam logic [7:0]  LATCH_RESET    = 8'hff;
  localparam logic [3:0]  ADDR_FIXED     = 4'h4;
  localparam logic [3:0]  BIT_LAST       = 4'h7;
  localparam logic [3:0]  BIT_ACK        = 4'h8;
  localparam logic [3:0]  BIT_ARMED      = 4'hf;   // start's own scl fall wraps this to zero
  localparam int          RW_POS         = 0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_IGNORE
  } slave_state_t;

  // sampled bus line pair
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  // bus condition events in one clock
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bus_events_t;
endpackage
`default_nettype wire

// ===== hdl/io_expander.sv
// sixteen-bit quasi-bidirectional port expander with i2c slave and change alert
// assumes open-drain pins resolved outside; pins and straps are asynchronous
`default_nettype none
module io_expander (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OE,
  input  wire logic [2:0]  SLAVE_ADDR_STRAP,
  input  wire logic [7:0]  LOW_OCTAL_PINS_IN,
  input  wire logic [7:0]  HIGH_OCTAL_PINS_IN,
  output logic [7:0]       LOW_OCTAL_PINS_OUT,
  output logic [7:0]       HIGH_OCTAL_PINS_OUT,
  output logic             ALERT_OE
);
  expander_pkg::bus_lines_t  pins_in;
  expander_pkg::bus_lines_t  lines;
  expander_pkg::bus_events_t ev;

  expander_pkg::slave_state_t state_reg, state_next;
  logic [3:0]  bit_reg;
  logic [7:0]  shift_reg;
  logic        octal_reg;        // 0 low octal, 1 high octal
  logic        ack_drive_reg;
  logic        out_bit_reg;
  logic        master_nack_reg;
  logic [7:0]  low_latch_reg;
  logic [7:0]  high_latch_reg;
  logic [15:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [2:0]  strap_meta_reg, strap_sync_reg;
  logic        low_pend_reg, high_pend_reg;
  logic        is_read_q;        // rw bit of the byte just acknowledged

  assign pins_in.scl = SCL_IN;
  assign pins_in.sda = SDA_IN;

  bus_sampler sampler (
    .clk    (CLK),
    .rstn   (RSTN),
    .pins   (pins_in),
    .lines  (lines),
    .events (ev)
  );

  // port and strap synchronisers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pin_meta_reg   <= 16'hffff;
      pin_sync_reg   <= 16'hffff;
      pin_prev_reg   <= 16'hffff;
      strap_meta_reg <= 3'h0;
      strap_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg   <= {HIGH_OCTAL_PINS_IN, LOW_OCTAL_PINS_IN};
      pin_sync_reg   <= pin_meta_reg;
      pin_prev_reg   <= pin_sync_reg;
      strap_meta_reg <= SLAVE_ADDR_STRAP;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // byte framing decode
  wire       byte_done  = ev.fall && bit_reg == expander_pkg::BIT_LAST;
  wire       ack_done   = ev.fall && bit_reg == expander_pkg::BIT_ACK;
  wire [7:0] rx_byte    = shift_reg;
  wire [6:0] my_addr    = {expander_pkg::ADDR_FIXED, strap_sync_reg};
  wire       addr_hit   = rx_byte[7:1] == my_addr;
  wire       is_read    = rx_byte[expander_pkg::RW_POS];
  wire       wr_store   = state_reg == expander_pkg::ST_WRITE && ack_done;
  wire       rd_load    = ack_done && !master_nack_reg &&
                          (state_reg == expander_pkg::ST_READ ||
                           (state_reg == expander_pkg::ST_ADDR && addr_hit && is_read));
  wire [7:0] rd_octal   = octal_reg ? pin_sync_reg[15:8] : pin_sync_reg[7:0];
  wire       rd_byte_go = rd_load;
  wire [15:0] pin_edge  = pin_sync_reg ^ pin_prev_reg;

  // slave sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      expander_pkg::ST_IDLE:   state_next = state_reg;
      expander_pkg::ST_ADDR: begin
        if (ack_done)
          state_next = !addr_hit ? expander_pkg::ST_IGNORE :
                       is_read ? expander_pkg::ST_READ : expander_pkg::ST_WRITE; // [R13] [R14]
      end
      expander_pkg::ST_READ: begin
        if (ack_done && master_nack_reg)
          state_next = expander_pkg::ST_IGNORE;
      end
      default: state_next = state_reg;
    endcase
    if (ev.start)
      state_next = expander_pkg::ST_ADDR;
    else if (ev.stop)
      state_next = expander_pkg::ST_IDLE;
  end

  // bit counter, shift register and octal pointer
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_reg <= expander_pkg::ST_IDLE;
      bit_reg   <= 4'h0;
      shift_reg <= 8'h00;
      octal_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // the scl fall that closes a start is not a data bit, so the count is armed
      // one below zero; counting it would shift every byte by one bit
      if (ev.start) begin
        bit_reg   <= expander_pkg::BIT_ARMED;
        octal_reg <= 1'b0;
      end else if (ev.stop) begin
        bit_reg   <= 4'h0;
        octal_reg <= 1'b0;
      end else if (ev.fall) begin
        bit_reg <= (bit_reg == expander_pkg::BIT_ACK) ? 4'h0 : bit_reg + 4'h1;
      end
      if (rd_byte_go)
        shift_reg <= rd_octal;                                     // [R8] [R2]
      else if (ev.rise && bit_reg <= expander_pkg::BIT_LAST &&
               state_reg != expander_pkg::ST_READ)
        shift_reg <= {shift_reg[6:0], lines.sda};
      else if (ev.fall && state_reg == expander_pkg::ST_READ &&
               bit_reg < expander_pkg::BIT_LAST)
        shift_reg <= {shift_reg[6:0], 1'b0};
      if (wr_store || (state_reg == expander_pkg::ST_READ && byte_done))
        octal_reg <= ~octal_reg;                                   // [R6] [R9]
    end
  end

  // sda drive: ack after address and write bytes, data bits during read
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ack_drive_reg   <= 1'b0;
      out_bit_reg     <= 1'b1;
      master_nack_reg <= 1'b0;
    end else begin
      if (ev.start || ev.stop) begin
        ack_drive_reg   <= 1'b0;
        master_nack_reg <= 1'b0;
      end else if (byte_done) begin
        ack_drive_reg <= (state_reg == expander_pkg::ST_ADDR && addr_hit) ||
                         state_reg == expander_pkg::ST_WRITE;
      end else if (ack_done) begin
        ack_drive_reg <= 1'b0;
      end
      if (ev.rise && bit_reg == expander_pkg::BIT_ACK)
        master_nack_reg <= lines.sda;
      else if (ev.start)
        master_nack_reg <= 1'b0;
      if (ev.start || ev.stop)
        out_bit_reg <= 1'b1;
      else if (rd_load)
        out_bit_reg <= rd_octal[7];
      else if (ev.fall && state_reg == expander_pkg::ST_READ)
        out_bit_reg <= (bit_reg < expander_pkg::BIT_LAST) ? shift_reg[6] : 1'b1;
    end
  end

  // read drive releases for the master's ack slot
  assign SDA_OE = ack_drive_reg ||
                  (state_reg == expander_pkg::ST_READ && !out_bit_reg &&
                   bit_reg != expander_pkg::BIT_ACK);

  // output latches, stored at the ack clock regardless of master ack
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      low_latch_reg  <= expander_pkg::LATCH_RESET;                 // [R12]
      high_latch_reg <= expander_pkg::LATCH_RESET;                 // [R12]
    end else if (wr_store) begin
      if (octal_reg)
        high_latch_reg <= rx_byte;                                 // [R5] [R6]
      else
        low_latch_reg  <= rx_byte;                                 // [R5] [R6]
    end
  end

  // quasi-bidirectional: a latched one only pulls up weakly, so pins can be inputs
  assign LOW_OCTAL_PINS_OUT  = low_latch_reg;
  assign HIGH_OCTAL_PINS_OUT = high_latch_reg;

  // pending change flags; a fresh edge wins over a clear in the same cycle
  wire low_clear  = wr_store || (state_reg == expander_pkg::ST_READ && byte_done && !octal_reg);
  wire high_clear = wr_store || (state_reg == expander_pkg::ST_READ && byte_done && octal_reg);
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      low_pend_reg  <= 1'b0;
      high_pend_reg <= 1'b0;
    end else begin
      low_pend_reg  <= (|pin_edge[7:0])  | (low_pend_reg  & ~low_clear);  // [R15] [R10] [R7]
      high_pend_reg <= (|pin_edge[15:8]) | (high_pend_reg & ~high_clear); // [R15] [R11] [R7]
    end
  end

  assign ALERT_OE = low_pend_reg | high_pend_reg;                  // [R16] [R3]

  // checks
  // steps of a byte hand-off, shared by the properties below
  sequence s_write_byte_end;
    state_reg == expander_pkg::ST_WRITE && byte_done && !ev.start && !ev.stop;
  endsequence
  sequence s_ack_held;
    SDA_OE [*2];
  endsequence
  sequence s_read_open;
    state_reg == expander_pkg::ST_ADDR && rd_load && !ev.start && !ev.stop;
  endsequence

  a_write_low_store: assert property (@(posedge CLK) disable iff (!RSTN)
    wr_store && !octal_reg |=> low_latch_reg == $past(rx_byte)) // [R5]
    else $error("low latch missed write byte");
  a_write_alternate: assert property (@(posedge CLK) disable iff (!RSTN)
    wr_store && !ev.start && !ev.stop |=> octal_reg != $past(octal_reg)) // [R6]
    else $error("write octal did not alternate");
  a_write_clears_all: assert property (@(posedge CLK) disable iff (!RSTN)
    wr_store && pin_edge == 16'h0000 |=> !ALERT_OE) // [R7]
    else $error("write left alert pending");
  a_read_load_pins: assert property (@(posedge CLK) disable iff (!RSTN)
    rd_load |=> shift_reg == $past(rd_octal)) // [R8]
    else $error("read byte not loaded from pins");
  a_read_starts_low: assert property (@(posedge CLK) disable iff (!RSTN)
    s_read_open |=> !octal_reg && shift_reg == $past(pin_sync_reg[7:0])) // [R9]
    else $error("read did not start at low octal");
  a_low_read_keeps: assert property (@(posedge CLK) disable iff (!RSTN)
    low_clear && !wr_store && high_pend_reg |=> high_pend_reg) // [R10]
    else $error("low read cleared high flag");
  a_high_read_keeps: assert property (@(posedge CLK) disable iff (!RSTN)
    high_clear && !wr_store && low_pend_reg |=> low_pend_reg) // [R11]
    else $error("high read cleared low flag");
  a_edge_alerts: assert property (@(posedge CLK) disable iff (!RSTN)
    |pin_edge |=> ALERT_OE) // [R15]
    else $error("pin edge did not raise alert");
  a_reset_latches: assert property (@(posedge CLK)
    !RSTN |=> LOW_OCTAL_PINS_OUT == 8'hff && HIGH_OCTAL_PINS_OUT == 8'hff) // [R12]
    else $error("latches not preset by reset");
  a_rw_select: assert property (@(posedge CLK) disable iff (!RSTN)
    state_reg == expander_pkg::ST_ADDR && ack_done && addr_hit && !ev.start && !ev.stop
    |=> state_reg == (is_read_q ? expander_pkg::ST_READ : expander_pkg::ST_WRITE)) // [R13] [R14]
    else $error("read/write bit misdecoded");
  a_alert_follows: assert property (@(posedge CLK) disable iff (!RSTN)
    (low_pend_reg && !low_clear) || (high_pend_reg && !high_clear) |=> ALERT_OE) // [R16]
    else $error("alert mismatch with flags");

  // rw bit held one cycle so a_rw_select sees the byte it decoded
  always_ff @(posedge CLK) begin
    is_read_q <= is_read;
  end

  // latches move only on a write store, and the high octal takes its own bytes
  a_write_high_store: assert property (@(posedge CLK) disable iff (!RSTN)
    wr_store && octal_reg |=> high_latch_reg == $past(rx_byte)) // [R5]
    else $error("high latch missed write byte");
  a_latch_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    !wr_store |=> $stable(low_latch_reg) && $stable(high_latch_reg)) // [R5]
    else $error("latch changed without a write byte");

  // a received write byte is acknowledged for at least two clocks
  a_write_ack: assert property (@(posedge CLK) disable iff (!RSTN)
    s_write_byte_end |=> s_ack_held) // [R5]
    else $error("write byte not acknowledged");

  // the address phase answers its own address and stays off the line otherwise
  a_addr_ack: assert property (@(posedge CLK) disable iff (!RSTN)
    state_reg == expander_pkg::ST_ADDR && byte_done && addr_hit && !ev.start && !ev.stop
    |=> SDA_OE) // [R13] [R14]
    else $error("own address not acknowledged");
  a_miss_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
    state_reg == expander_pkg::ST_IGNORE |-> !SDA_OE) // [R13] [R14]
    else $error("sda driven while not addressed");

  // the acknowledge slot of a read belongs to the master, and its nack ends the read
  a_read_ack_free: assert property (@(posedge CLK) disable iff (!RSTN)
    state_reg == expander_pkg::ST_READ && bit_reg == expander_pkg::BIT_ACK
    |-> !SDA_OE) // [R9]
    else $error("sda driven in master ack slot");
  a_nack_ends_read: assert property (@(posedge CLK) disable iff (!RSTN)
    state_reg == expander_pkg::ST_READ && ack_done && master_nack_reg && !ev.start
    |=> state_reg == expander_pkg::ST_IGNORE && !SDA_OE) // [R9]
    else $error("read went on after master nack");

  // every second read byte takes the high pins, and stop rewinds the pointer
  a_read_high_load: assert property (@(posedge CLK) disable iff (!RSTN)
    state_reg == expander_pkg::ST_READ && rd_load && octal_reg
    |=> shift_reg == $past(pin_sync_reg[15:8])) // [R9] [R2]
    else $error("high read byte not loaded from pins");
  a_stop_rewinds: assert property (@(posedge CLK) disable iff (!RSTN)
    ev.stop |=> !octal_reg) // [R6] [R9]
    else $error("stop left octal pointer high");

  // an edge sets the flag of its own octal; both flags clear releases the line
  a_low_edge_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    |pin_edge[7:0] |=> low_pend_reg) // [R15] [R16]
    else $error("low pin edge did not set low flag");
  a_high_edge_flag: assert property (@(posedge CLK) disable iff (!RSTN)
    |pin_edge[15:8] |=> high_pend_reg) // [R15] [R16]
    else $error("high pin edge did not set high flag");
  a_alert_release: assert property (@(posedge CLK) disable iff (!RSTN)
    !low_pend_reg && !high_pend_reg |-> !ALERT_OE) // [R16]
    else $error("alert held with both flags clear");

  // reset leaves both open-drain outputs released, and an idle bus leaves sda released
  a_reset_quiet: assert property (@(posedge CLK)
    !RSTN |=> !SDA_OE && !ALERT_OE) // [R12]
    else $error("outputs driven after reset");
  a_idle_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
    state_reg == expander_pkg::ST_IDLE |-> !SDA_OE) // [R12]
    else $error("sda driven on idle bus");
endmodule
`default_nettype wire

// ===== sim/i2c_master_model.sv
// bus master model: bit-banged i2c master driving scl and an open-drain sda pull
// assumes the bench resolves sda with a pull-up and hands the wire level back
`default_nettype none
module i2c_master_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // quarter of a bit; 31.25 ns gives the 125 ns link clock, the bench may slow it
  realtime qtr = 31.25;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one quarter bit with both lines set; scl stands high between frames
  task automatic step(input logic c, input logic l);
    scl = c;
    sda_low = l;
    #qtr;
  endtask

  // data set in the low phase, sampled mid high, held a quarter past the fall
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, !b);
    step(1'b1, !b);
    r = sda;
    step(1'b1, !b);
    step(1'b0, !b);
  endtask

  // start from idle: sda falls while scl is high
  task automatic bus_start();
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask

  // stop: sda rises while scl is high, then both lines rest released
  task automatic bus_stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask

  // byte out msb first; ack is the slave pulling sda low in the ninth bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // byte in msb first; a high ninth bit tells the slave the read is over
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

// ===== sim/io_expander_tb_top.sv
// self-checking bench for the port expander: random writes, reads and pin changes
// assumes quasi-bidirectional pins, modelled as latch level anded with outside pull-downs
`default_nettype none
module io_expander_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] strap = 3'h5;
  logic [7:0] ext_lo = 8'hff;
  logic [7:0] ext_hi = 8'hff;
  logic [7:0] lo_out;
  logic [7:0] hi_out;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] rd;
  logic       scl;
  logic       m_low;
  logic       sda_oe;
  logic       alert_oe;
  logic       ack;
  int         err_total = 0;
  int         tests_run = 0;
  wire  logic sda = !(m_low | sda_oe);   // pull-up when nobody pulls low

  always #4 clk = ~clk;

  i2c_master_model i_master (.scl(scl), .sda_low(m_low), .sda(sda));
  io_expander i_dut (
    .CLK(clk), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OE(sda_oe),
    .SLAVE_ADDR_STRAP(strap), .LOW_OCTAL_PINS_IN(lo_out & ext_lo),
    .HIGH_OCTAL_PINS_IN(hi_out & ext_hi), .LOW_OCTAL_PINS_OUT(lo_out),
    .HIGH_OCTAL_PINS_OUT(hi_out), .ALERT_OE(alert_oe));

  // a pin reads low if either the latch or the outside world pulls it
  function automatic logic [7:0] pin_level(input logic [7:0] latch, input logic [7:0] ext);
    return latch & ext;
  endfunction

  function automatic logic [7:0] addr_byte(input logic [2:0] s, input logic rw);
    return {expander_pkg::ADDR_FIXED, s, rw};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // sample on the falling edge so registered outputs have settled
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic open_xfer(input logic [2:0] s, input logic rw, input logic exp_ack);
    i_master.bus_start();
    i_master.send_byte(addr_byte(s, rw), ack);
    check({7'h0, ack}, {7'h0, exp_ack}, "address ack");
  endtask

  // latch updates a few clocks after the ninth scl fall
  task automatic wr(input logic [7:0] b, input logic hi_side);
    i_master.send_byte(b, ack);
    check({7'h0, ack}, 8'h01, "data ack");
    wait_clk(6);
    check(hi_side ? hi_out : lo_out, b, "latch");
  endtask

  task automatic rd_chk(input logic [7:0] exp, input logic nack);
    i_master.recv_byte(nack, rd);
    check(rd, exp, "read byte");
  endtask

  task automatic alert_is(input logic exp, input string what);
    wait_clk(10);
    check({7'h0, alert_oe}, {7'h0, exp}, what);
  endtask

  task automatic conclude();
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // whole run is about 83 us of bus traffic, well under the 200 us limit
  initial begin
    #200000;
    err_total++;
    conclude();
  end

  initial begin
    void'($urandom(41065));
    @(posedge clk);
    @(negedge clk);
    check(lo_out, expander_pkg::LATCH_RESET, "reset low latch");
    check(hi_out, expander_pkg::LATCH_RESET, "reset high latch");
    @(posedge clk);
    rstn <= 1'b1;
    wait_clk(4);
    check({6'h0, alert_oe, sda_oe}, 8'h00, "idle outputs");
    // another strap value must be ignored
    open_xfer(strap ^ 3'h2, 1'b0, 1'b0);
    i_master.bus_stop();
    // random latch data and pin pulls, three-byte write then three-byte read
    for (int k = 0; k < 4; k++) begin
      if (k == 3)
        i_master.qtr = 62.5;
      lo = 8'($urandom);
      hi = 8'($urandom);
      open_xfer(strap, 1'b0, 1'b1);
      wr(8'($urandom), 1'b0);
      wr(hi, 1'b1);
      wr(lo, 1'b0);
      check(hi_out, hi, "high kept");
      i_master.bus_stop();
      @(posedge clk);
      ext_lo <= 8'($urandom);
      ext_hi <= 8'($urandom);
      wait_clk(8);
      open_xfer(strap, 1'b1, 1'b1);
      rd_chk(pin_level(lo, ext_lo), 1'b0);
      rd_chk(pin_level(hi, ext_hi), 1'b0);
      rd_chk(pin_level(lo, ext_lo), 1'b1);
      i_master.bus_stop();
    end
    // release every pin as an input and let the outside drive them
    @(posedge clk);
    ext_lo <= 8'hff;
    ext_hi <= 8'hff;
    open_xfer(strap, 1'b0, 1'b1);
    wr(8'hff, 1'b0);
    wr(8'hff, 1'b1);
    // the latch changes above are pin edges too; this byte clears what they raised
    wr(8'hff, 1'b0);
    i_master.bus_stop();
    alert_is(1'b0, "alert after write");
    @(posedge clk);
    ext_lo <= 8'($urandom) & 8'hfe;
    ext_hi <= 8'($urandom) & 8'h7f;
    alert_is(1'b1, "alert on pin edges");
    open_xfer(strap, 1'b1, 1'b1);
    rd_chk(ext_lo, 1'b1);
    i_master.bus_stop();
    alert_is(1'b1, "high pending after low read");
    open_xfer(strap, 1'b1, 1'b1);
    rd_chk(ext_lo, 1'b0);
    rd_chk(ext_hi, 1'b1);
    i_master.bus_stop();
    alert_is(1'b0, "alert after both reads");
    // a single write to the low octal must also drop a high octal change
    @(posedge clk);
    ext_hi <= ext_hi ^ 8'h81;
    alert_is(1'b1, "alert on high edge");
    open_xfer(strap, 1'b0, 1'b1);
    wr(8'hff, 1'b0);
    i_master.bus_stop();
    alert_is(1'b0, "alert after low write");
    // a low pin changes between the two bytes: reading high must leave it pending
    open_xfer(strap, 1'b1, 1'b1);
    rd_chk(ext_lo, 1'b0);
    @(posedge clk);
    ext_lo <= ext_lo ^ 8'h10;
    rd_chk(ext_hi, 1'b1);
    i_master.bus_stop();
    alert_is(1'b1, "low pending after high read");
    conclude();
  end
endmodule
`default_nettype wire
